// File: rtl/lsbot_cfg.svh
// constants of the led sink blink off-time timer
`ifndef LSBOT_CFG_SVH
`define LSBOT_CFG_SVH

// ----------------------------------------------------------------
// register map, byte addresses on apb
// ----------------------------------------------------------------
`define LSBOT_ADDR_W 8
`define LSBOT_OFS_ENABLE 8'h00
`define LSBOT_OFS_LIT 8'h04
`define LSBOT_OFS_DARK_LOW 8'h08
`define LSBOT_OFS_STATUS 8'h0C

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define LSBOT_SINKS 4
`define LSBOT_CODE_W 2
`define LSBOT_DARK_W 8
`define LSBOT_SINK4_DARK_HI 7
`define LSBOT_SINK4_DARK_LO 6
`define LSBOT_SINK3_DARK_HI 5
`define LSBOT_SINK3_DARK_LO 4
`define LSBOT_SINK2_DARK_HI 3
`define LSBOT_SINK2_DARK_LO 2
`define LSBOT_SINK1_DARK_HI 1
`define LSBOT_SINK1_DARK_LO 0
`define LSBOT_ENABLE_HI 3
`define LSBOT_LIT_HI 1
`define LSBOT_STAT_DARK_LO 4
`define LSBOT_STAT_DARK_HI 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LSBOT_RST_ENABLE 4'h0
`define LSBOT_RST_LIT 2'h0
`define LSBOT_RST_DARK 8'h00

// ----------------------------------------------------------------
// timing: intervals in ms, one tick is the common grain
// ----------------------------------------------------------------
`define LSBOT_CLK_KHZ 200000
`define LSBOT_TICK_MS 200
`define LSBOT_TICK_CYCLES (`LSBOT_TICK_MS * `LSBOT_CLK_KHZ)
`define LSBOT_DARK1_MS 600
`define LSBOT_DARK2_MS 1200
`define LSBOT_DARK3_MS 1800
`define LSBOT_LIT0_MS 200
`define LSBOT_LIT1_MS 600
`define LSBOT_LIT2_MS 800
`define LSBOT_LIT3_MS 1200
`define LSBOT_TCNT_W 4

`endif

// File: rtl/lsbot_pkg.sv
// types and interval decoding of the led sink blink off-time timer
`include "lsbot_cfg.svh"

package lsbot_pkg;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [`LSBOT_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } lsbot_apb_req_t;

    typedef enum logic [1:0] {
        LSBOT_IDLE = 2'b00,
        LSBOT_LIT = 2'b01,
        LSBOT_DARK = 2'b10
    } lsbot_phase_t;

    // dark interval in ticks, zero when the code disables it
    function automatic logic [`LSBOT_TCNT_W-1:0] dark_ticks(input logic [1:0] code);
        case (code)
            2'h1: dark_ticks = `LSBOT_TCNT_W'(`LSBOT_DARK1_MS / `LSBOT_TICK_MS);
            2'h2: dark_ticks = `LSBOT_TCNT_W'(`LSBOT_DARK2_MS / `LSBOT_TICK_MS);
            2'h3: dark_ticks = `LSBOT_TCNT_W'(`LSBOT_DARK3_MS / `LSBOT_TICK_MS);
            default: dark_ticks = '0;
        endcase
    endfunction

    function automatic logic [`LSBOT_TCNT_W-1:0] lit_ticks(input logic [1:0] code);
        case (code)
            2'h0: lit_ticks = `LSBOT_TCNT_W'(`LSBOT_LIT0_MS / `LSBOT_TICK_MS);
            2'h1: lit_ticks = `LSBOT_TCNT_W'(`LSBOT_LIT1_MS / `LSBOT_TICK_MS);
            2'h2: lit_ticks = `LSBOT_TCNT_W'(`LSBOT_LIT2_MS / `LSBOT_TICK_MS);
            default: lit_ticks = `LSBOT_TCNT_W'(`LSBOT_LIT3_MS / `LSBOT_TICK_MS);
        endcase
    endfunction

endpackage

// File: rtl/lsbot_sink.sv
// one sink's lit/dark sequencer, stepped by the common slow tick
`timescale 1ns/1ps
`include "lsbot_cfg.svh"
`default_nettype none

module lsbot_sink (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic tick,
    input wire logic sink_enable,
    input wire logic [`LSBOT_CODE_W-1:0] dark_code,
    input wire logic [`LSBOT_CODE_W-1:0] lit_code,
    output logic sink_on,
    output lsbot_pkg::lsbot_phase_t phase
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [`LSBOT_TCNT_W-1:0] count;
    logic [`LSBOT_TCNT_W-1:0] next_count;
    logic [`LSBOT_TCNT_W-1:0] count_inc;
    logic [`LSBOT_TCNT_W-1:0] dark_len;
    logic [`LSBOT_TCNT_W-1:0] lit_len;
    logic blinking;
    logic lit_done;
    logic dark_done;
    lsbot_pkg::lsbot_phase_t next_phase;

    assign dark_len = lsbot_pkg::dark_ticks(dark_code);
    assign lit_len = lsbot_pkg::lit_ticks(lit_code);
    assign blinking = (dark_code != '0);
    assign count_inc = count + `LSBOT_TCNT_W'(1);
    assign lit_done = tick && blinking && (count_inc >= lit_len);
    assign dark_done = tick && (count_inc >= dark_len);

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_comb begin
        next_phase = phase;
        next_count = count;
        case (phase)
            lsbot_pkg::LSBOT_IDLE: begin
                next_count = '0;
                if (sink_enable) begin
                    next_phase = lsbot_pkg::LSBOT_LIT;
                end
            end
            lsbot_pkg::LSBOT_LIT: begin
                if (!blinking) begin
                    next_count = '0;
                end else if (lit_done) begin
                    next_phase = lsbot_pkg::LSBOT_DARK;
                    next_count = '0;
                end else if (tick) begin
                    next_count = count_inc;
                end
            end
            lsbot_pkg::LSBOT_DARK: begin
                // a code cleared to 00 mid-dark relights at once
                if (!blinking || dark_done) begin
                    next_phase = lsbot_pkg::LSBOT_LIT;
                    next_count = '0;
                end else if (tick) begin
                    next_count = count_inc;
                end
            end
            default: begin
                next_phase = lsbot_pkg::LSBOT_IDLE;
                next_count = '0;
            end
        endcase
        if (!sink_enable) begin
            next_phase = lsbot_pkg::LSBOT_IDLE;
            next_count = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            phase <= lsbot_pkg::LSBOT_IDLE;
            count <= '0;
            sink_on <= 1'b0;
        end else if (ce) begin
            phase <= next_phase;
            count <= next_count;
            sink_on <= (next_phase == lsbot_pkg::LSBOT_LIT);
        end
    end

endmodule // lsbot_sink

`default_nettype wire

// File: rtl/lsbot_top.sv
// apb-reached blink timer for four independent led current sinks
//
// Contract
// - dark code 00/01/10/11: none, 0.6/1.2/1.8 s
// - enabled sink, dark code 00: stays lit
// - nonzero code: lit interval, then dark, repeating
// - sink 4 dark code in bits 7:6
// - sink 3 dark code in bits 5:4
// - sink 2 dark code in bits 3:2
// - sink 1 dark code in bits 1:0
// - shared lit code: 0.2/0.6/0.8/1.2 s
// - enable bits 3..0 switch sinks 4..1
`timescale 1ns/1ps
`include "lsbot_cfg.svh"
`default_nettype none

module lsbot_top #(
    parameter int unsigned TICK_CYCLES = `LSBOT_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`LSBOT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`LSBOT_SINKS-1:0] sink_on
);

    // ------------------------------------------------------------
    // bus request bundle
    // ------------------------------------------------------------
    lsbot_pkg::lsbot_apb_req_t req;

    // one driver for the whole bundle, field order as the package packs it
    assign req = {psel, penable, pwrite, paddr, pwdata};

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [`LSBOT_SINKS-1:0] sink_enable;
    logic [`LSBOT_CODE_W-1:0] shared_lit_interval;
    logic [`LSBOT_DARK_W-1:0] sink_dark_interval_low;

    wire logic [`LSBOT_CODE_W-1:0] sink4_dark_interval;
    wire logic [`LSBOT_CODE_W-1:0] sink3_dark_interval;
    wire logic [`LSBOT_CODE_W-1:0] sink2_dark_interval;
    wire logic [`LSBOT_CODE_W-1:0] sink1_dark_interval;
    wire logic [`LSBOT_SINKS*`LSBOT_CODE_W-1:0] dark_codes;

    assign sink4_dark_interval =
        sink_dark_interval_low[`LSBOT_SINK4_DARK_HI:`LSBOT_SINK4_DARK_LO];
    assign sink3_dark_interval =
        sink_dark_interval_low[`LSBOT_SINK3_DARK_HI:`LSBOT_SINK3_DARK_LO];
    assign sink2_dark_interval =
        sink_dark_interval_low[`LSBOT_SINK2_DARK_HI:`LSBOT_SINK2_DARK_LO];
    assign sink1_dark_interval =
        sink_dark_interval_low[`LSBOT_SINK1_DARK_HI:`LSBOT_SINK1_DARK_LO];
    assign dark_codes = {sink4_dark_interval, sink3_dark_interval,
                         sink2_dark_interval, sink1_dark_interval};

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic setup_phase;
    wire logic access_done;
    wire logic hit_enable;
    wire logic hit_lit;
    wire logic hit_dark;
    wire logic hit_status;
    wire logic hit_any;
    wire logic wr_enable;
    wire logic wr_lit;
    wire logic wr_dark;

    assign setup_phase = req.sel && !req.enable;
    assign access_done = req.sel && req.enable && pready;
    assign hit_enable = (req.addr == `LSBOT_OFS_ENABLE);
    assign hit_lit = (req.addr == `LSBOT_OFS_LIT);
    assign hit_dark = (req.addr == `LSBOT_OFS_DARK_LOW);
    assign hit_status = (req.addr == `LSBOT_OFS_STATUS);
    assign hit_any = hit_enable || hit_lit || hit_dark || hit_status;
    assign wr_enable = access_done && req.write && hit_enable;
    assign wr_lit = access_done && req.write && hit_lit;
    assign wr_dark = access_done && req.write && hit_dark;

    // ------------------------------------------------------------
    // read data, prepared during setup so it can leave a flop
    // ------------------------------------------------------------
    wire logic [31:0] status_word;
    wire logic [31:0] next_prdata;
    wire logic [`LSBOT_SINKS-1:0] sink_on_w;
    wire logic [`LSBOT_SINKS-1:0] sink_dark_w;

    assign status_word = {{(32 - `LSBOT_STAT_DARK_HI - 1){1'b0}},
                          sink_dark_w, sink_on_w};
    assign next_prdata =
        hit_enable ? {{(32 - `LSBOT_SINKS){1'b0}}, sink_enable} :
        hit_lit ? {{(32 - `LSBOT_CODE_W){1'b0}}, shared_lit_interval} :
        hit_dark ? {{(32 - `LSBOT_DARK_W){1'b0}}, sink_dark_interval_low} :
        hit_status ? status_word : 32'h0000_0000;

    // one wait-free access phase: pready rises in the first access cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            if (setup_phase && !req.write) begin
                prdata <= next_prdata;
            end
        end
    end

    // ------------------------------------------------------------
    // register writes; status and unmapped writes are dropped
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sink_enable <= `LSBOT_RST_ENABLE;
            shared_lit_interval <= `LSBOT_RST_LIT;
            sink_dark_interval_low <= `LSBOT_RST_DARK;
        end else if (ce) begin
            if (wr_enable) begin
                sink_enable <= req.wdata[`LSBOT_ENABLE_HI:0];
            end
            if (wr_lit) begin
                shared_lit_interval <= req.wdata[`LSBOT_LIT_HI:0];
            end
            if (wr_dark) begin
                sink_dark_interval_low <= req.wdata[`LSBOT_DARK_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // slow time base
    // ------------------------------------------------------------
    // the tick free-runs, so the first lit interval after enable can
    // be short by up to one tick; this keeps every sink in step
    logic [31:0] tick_div;
    logic tick;
    wire logic tick_wrap;

    assign tick_wrap = (tick_div == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (!nrst) begin
            tick_div <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= tick_wrap;
            tick_div <= tick_wrap ? 32'h0000_0000 : tick_div + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // per-sink sequencers
    // ------------------------------------------------------------
    lsbot_pkg::lsbot_phase_t phase [`LSBOT_SINKS];

    genvar g;
    generate
        for (g = 0; g < `LSBOT_SINKS; g = g + 1) begin : g_sink
            lsbot_sink u_sink (
                .clock(clock),
                .nrst(nrst),
                .ce(ce),
                .tick(tick),
                .sink_enable(sink_enable[g]),
                .dark_code(dark_codes[g*`LSBOT_CODE_W +: `LSBOT_CODE_W]),
                .lit_code(shared_lit_interval),
                .sink_on(sink_on_w[g]),
                .phase(phase[g])
            );
            assign sink_dark_w[g] = (phase[g] == lsbot_pkg::LSBOT_DARK);
        end
    endgenerate

    assign sink_on = sink_on_w;

endmodule // lsbot_top

`default_nettype wire

// File: bench/lsbot_top_properties.sv
// concurrent checks on the ports of the led sink blink timer
`timescale 1ns/1ps
`default_nettype none

module lsbot_top_properties #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] sink_on
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // shadow of the written enable and dark registers, and state derived from them
    // ----------------------------------------------------------------
    logic [3:0] en_sh;
    logic [7:0] dark_sh;
    logic [3:0] hold_q;
    logic [15:0] low_cnt;
    wire setup = psel && !penable && ce;
    wire done_wr = psel && penable && pready && pwrite;
    wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
    wire [3:0] code_zero = {dark_sh[7:6] == 2'h0, dark_sh[5:4] == 2'h0,
        dark_sh[3:2] == 2'h0, dark_sh[1:0] == 2'h0};
    always_ff @(posedge clock) begin
        if (!nrst) begin
            en_sh <= '0;
            dark_sh <= '0;
        end else if (done_wr && paddr == 8'h00) begin
            en_sh <= pwdata[3:0];
        end else if (done_wr && paddr == 8'h08) begin
            dark_sh <= pwdata[7:0];
        end
    end
    always_ff @(posedge clock) begin
        hold_q <= nrst ? (en_sh & code_zero) : 4'h0;
        if (!nrst || !en_sh[3] || sink_on[3]) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + 16'h1;
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_answer; setup |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_unmapped; setup && !mapped |=> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped; setup && mapped |=> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("error on a mapped access");
    property p_dark_read; setup && !pwrite && paddr == 8'h08 |=> prdata == {24'h0, dark_sh};
    endproperty
    a_dark_read: assert property (p_dark_read) else $error("dark field readback");
    property p_steady; (hold_q & en_sh & code_zero & ~sink_on) == 4'h0; endproperty
    a_steady: assert property (p_steady) else $error("steady sink went dark");
    property p_off; (~en_sh & ~$past(en_sh) & sink_on) == 4'h0; endproperty
    a_off: assert property (p_off) else $error("disabled sink lit");
    property p_start; $rose(en_sh[2]) |=> sink_on[2]; endproperty
    a_start: assert property (p_start) else $error("enable did not start lit");
    // +2 allows the one-edge lag between the enable and the first lit cycle
    property p_dark_bound; low_cnt <= 32'(dark_sh[7:6]) * 3 * TICK_CYCLES + 2; endproperty
    a_dark_bound: assert property (p_dark_bound) else $error("dark too long");
    c_err: cover property (pslverr);
    c_blink: cover property (sink_on[3] ##1 !sink_on[3]);
    c_write: cover property (pready && pwrite);
endmodule // lsbot_top_properties
`default_nettype wire

// File: bench/lsbot_sink_drv_model.sv
// led sink drivers: record the length of each lit and dark run in cycles
`timescale 1ns/1ps
`default_nettype none

module lsbot_sink_drv_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] sink_on,
    output logic [3:0][15:0] last_lit,
    output logic [3:0][15:0] last_dark
);
    logic [3:0][15:0] run;
    logic [3:0] prev;
    always @(posedge clock) begin
        prev <= nrst ? sink_on : 4'h0;
        for (int k = 0; k < 4; k++) begin
            if (!nrst) begin
                run[k] <= '0;
                last_lit[k] <= '0;
                last_dark[k] <= '0;
            end else if (sink_on[k] === prev[k]) begin
                run[k] <= run[k] + 16'h1;
            end else begin
                if (prev[k]) last_lit[k] <= run[k];
                else last_dark[k] <= run[k];
                run[k] <= 16'h1;
            end
        end
    end
endmodule // lsbot_sink_drv_model
`default_nettype wire

// File: bench/lsbot_top_tb.sv
// self-checking bench of the led sink blink timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module lsbot_top_tb;
    // short tick keeps the run small; every interval below scales from it
    localparam int unsigned TICK = 10;
    logic clock, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] sink_on;
    logic [3:0][15:0] last_lit, last_dark;
    int n_fail = 0;
    int samples_checked = 0;
    lsbot_top #(.TICK_CYCLES(TICK)) lsbot_top_inst (.clock(clock), .nrst(nrst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sink_on(sink_on));
    lsbot_sink_drv_model lsbot_sink_drv_model_inst (.clock(clock), .nrst(nrst),
        .sink_on(sink_on), .last_lit(last_lit), .last_dark(last_dark));
    // ----------------------------------------------------------------
    // apb master and scenarios
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, 8'h08, 32'hFFFF_FFE4);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0000_00E4)
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        `CHK(er, 1'b0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        $display("test regs done");
    endtask
    task automatic t_dark();
        int off1;
        off1 = 0;
        apb(1'b1, 8'h00, 32'h0000_000F);
        repeat (3) @(posedge clock);
        repeat (400) begin
            @(posedge clock);
            if (sink_on[0] !== 1'b1) off1++;
        end
        `CHK(off1, 0)
        `CHK(last_dark[1], 16'(3 * TICK))
        `CHK(last_dark[2], 16'(6 * TICK))
        `CHK(last_dark[3], 16'(9 * TICK))
        `CHK(last_lit[3], 16'(TICK))
        apb(1'b0, 8'h0C, 32'h0);
        `CHK({rd[31:8], rd[4], rd[0]}, {24'h0, 2'b01})
        `CHK(rd[7:4] ^ rd[3:0], 4'hF)
        $display("test dark done");
    endtask
    task automatic t_lit();
        int lt[4] = '{1, 3, 4, 6};
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, 8'h04, 32'(c));
            repeat (300) @(posedge clock);
            `CHK(last_lit[1], 16'(lt[c] * TICK))
        end
        $display("test lit done");
    endtask
    task automatic t_clear();
        apb(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge clock);
        `CHK(sink_on, 4'h0)
        apb(1'b1, 8'h00, 32'h0000_0004);
        repeat (2) @(posedge clock);
        `CHK(sink_on, 4'h4)
        $display("test clear done");
    endtask
    // sink 3 is blinking here, so a frozen clock enable must hold its level
    task automatic t_freeze();
        logic [3:0] held;
        @(posedge clock);
        ce <= 1'b0;
        @(posedge clock);
        held = sink_on;
        repeat (100) begin
            @(posedge clock);
            `CHK(sink_on, held)
        end
        ce <= 1'b1;
        $display("test freeze done");
    endtask
    task automatic t_reset();
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(sink_on, 4'h0)
        nrst <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0)
        $display("test reset done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_dark();
        t_lit();
        t_clear();
        t_freeze();
        t_reset();
        tally_and_finish();
    end
endmodule // lsbot_top_tb

bind lsbot_top lsbot_top_properties #(.TICK_CYCLES(TICK_CYCLES)) lsbot_top_properties_inst (
    .clock(clock), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sink_on(sink_on));
`default_nettype wire
